// ==== xcvr_consts.svh ====
`ifndef XCVR_CONSTS_SVH
`define XCVR_CONSTS_SVH

// serial frame: bit 15 read flag, 14:8 address, 7:0 data, msb first
`define SER_FRAME_BITS   5'd16
`define SER_DATA_START   5'd8
`define SER_RW_BIT       15
`define SER_ADDR_HI      14
`define SER_ADDR_LO      8

// register addresses on the serial link
`define REG_MODE         7'h00
`define REG_A1           7'h0f
`define REG_N1_HI        7'h10
`define REG_N1_LO        7'h11
`define REG_M1_HI        7'h12
`define REG_M1_LO        7'h13
`define REG_BIAS         7'h14
`define REG_FEE_CTRL     7'h15
`define REG_FEE_RES      7'h16

// writable bits of each partly writable register
`define MASK_MODE        8'h1f
`define MASK_A1          8'h3f
`define MASK_HI_NIBBLE   8'h0f
`define MASK_FEE_CTRL    8'h0f

// mode register layout
`define MODE_OP_HI       1
`define MODE_OP_LO       0
`define MODE_SYNC_BIT    2
`define MODE_MOD_HI      4
`define MODE_MOD_LO      3

// fixed bias field values
`define BIAS_HALVER_VAL  8'h80
`define BIAS_OSC_VAL     8'h20
`define BIAS_AMP_VAL     8'h10
`define BIAS_BUF_VAL     8'h05

// reset values
`define RST_BYTE         8'h00
`define RST_A1           6'h00
`define RST_DIV          12'h000

// timing in clk cycles
`define BIT_PERIOD       8'd16
`define BIT_HALF         8'd8
`define SCLK_HALF        4'd4

// apb map of the controller
`define APB_CMD          12'h000
`define APB_STATUS       12'h004
`define ST_BUSY_BIT      0
`define ST_REFUSED_BIT   1
`define ST_RD_HI         15
`define ST_RD_LO         8

`endif

// ==== xcvr_pkg.sv ====
package xcvr_pkg;

  typedef enum logic [1:0] {
    OP_POWER_DOWN = 2'h0,
    OP_STANDBY    = 2'h1,
    OP_RECEIVE    = 2'h2,
    OP_TRANSMIT   = 2'h3
  } op_state_e;

  typedef enum logic [1:0] {
    MOD_CLOSED_LOOP = 2'h0,
    MOD_OPEN_LOOP   = 2'h1,
    MOD_IN_PLL      = 2'h2,
    MOD_RESERVED    = 2'h3
  } mod_sel_e;

  typedef enum logic [1:0] {
    FEE_OFF     = 2'h0,
    FEE_UP_ONLY = 2'h1,
    FEE_DN_ONLY = 2'h2,
    FEE_UP_DN   = 2'h3
  } fee_mode_e;

  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_LOW  = 4'h2,
    H_HIGH = 4'h4,
    H_END  = 4'h8
  } host_state_e;

endpackage : xcvr_pkg

// ==== cfg_link_if.sv ====
`timescale 1ns/1ps
interface cfg_link_if;
  logic sclk;
  logic sen;
  logic sdata_h_out;
  logic sdata_h_oe;
  logic sdata_d_out;
  logic sdata_d_oe;
  logic sdata_line;

  // open line idles high
  assign sdata_line = sdata_h_oe ? sdata_h_out :
                      (sdata_d_oe ? sdata_d_out : 1'b1);

  modport dev (
    input  sclk,
    input  sen,
    input  sdata_line,
    output sdata_d_out,
    output sdata_d_oe
  );

  modport host (
    output sclk,
    output sen,
    output sdata_h_out,
    output sdata_h_oe,
    input  sdata_line
  );
endinterface : cfg_link_if

// ==== fee_counter.sv ====
`timescale 1ns/1ps
`include "xcvr_consts.svh"
module fee_counter import xcvr_pkg::*; (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [1:0] mode,
  input  wire logic       up_pulse,
  input  wire logic       dn_pulse,
  output logic      [7:0] value
);
  logic [7:0] next_value;

  // wraps modulo 256; off holds the last result for read-back
  always_comb begin
    next_value = value;
    case (fee_mode_e'(mode))
      FEE_OFF:     next_value = value;
      FEE_UP_ONLY: next_value = value + {7'h00, up_pulse};
      FEE_DN_ONLY: next_value = value - {7'h00, dn_pulse};
      FEE_UP_DN:   next_value = value + {7'h00, up_pulse}
                                      - {7'h00, dn_pulse};
      default:     next_value = value;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      value <= `RST_BYTE;
    end else begin
      value <= next_value;
    end
  end
endmodule : fee_counter

// ==== xcvr_device.sv ====
`timescale 1ns/1ps
`include "xcvr_consts.svh"
// Summary of operation
// - mode field picks power-down, standby, receive, transmit
// - receive, sync off: data passes through unsynchronised
// - transmit, sync off: bit clock pin idle
// - sync on: own bit clock, rx sync, tx pin
// - modulation field encodings; reserved code never written
// - host always sets bias bit 7
// - host writes oscillator buffer bias as 01
// - host writes amplifier bias bits as 10
// - host writes amplifier buffer bias as 101
// - estimate is one byte, bit 7 msb
// - estimator counts per low two control bits
module xcvr_device import xcvr_pkg::*; (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  cfg_link_if.dev          link,
  input  wire logic        demod_data,
  input  wire logic        tx_data_in,
  input  wire logic        fee_up_pulse,
  input  wire logic        fee_dn_pulse,
  output logic             xco_en,
  output logic             rx_chain_en,
  output logic             tx_chain_en,
  output logic             pa_stage_en,
  output logic       [1:0] mod_method,
  output logic             rx_data_out,
  output logic             tx_mod_data,
  output logic             bit_clock_out_pin,
  output logic       [5:0] set1_swallow_count,
  output logic      [11:0] set1_main_divider,
  output logic      [11:0] set1_ref_divider,
  output logic       [7:0] bias_config,
  output logic       [3:0] error_est_ctrl
);
  // serial shifter state
  logic        sclk_q;
  logic        sen_q;
  logic [4:0]  bit_cnt;
  logic [15:0] in_sh;
  logic [7:0]  out_sh;
  logic        out_oe;
  logic [4:0]  next_bit_cnt;
  logic [15:0] next_in_sh;
  logic [7:0]  next_out_sh;
  logic        next_out_oe;

  // configuration state
  logic [1:0]  op_state_sel;
  logic        sync_en;
  logic [1:0]  mod_method_sel;
  logic [1:0]  next_op_state_sel;
  logic        next_sync_en;
  logic [1:0]  next_mod_method_sel;
  logic [5:0]  next_swallow;
  logic [11:0] next_main_div;
  logic [11:0] next_ref_div;
  logic [7:0]  next_bias;
  logic [3:0]  next_fee_ctrl;

  // bit synchroniser state
  logic [7:0]  phase;
  logic        demod_q;
  logic        rx_q;
  logic        tx_q;
  logic [7:0]  next_phase;
  logic        next_rx_q;
  logic        next_tx_q;

  logic [7:0]  freq_error_estimate;
  logic [7:0]  rd_value;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        frame_end;
  logic [6:0]  frame_addr;
  logic [7:0]  frame_data;
  logic        do_write;
  logic        is_read;
  op_state_e   op_state;

  assign sclk_rise  = link.sclk & ~sclk_q;
  assign sclk_fall  = ~link.sclk & sclk_q;
  assign frame_end  = sen_q & ~link.sen;
  assign is_read    = in_sh[`SER_RW_BIT];
  assign frame_addr = in_sh[`SER_ADDR_HI:`SER_ADDR_LO];
  assign frame_data = in_sh[7:0];
  // a short or aborted frame commits nothing
  assign do_write   = frame_end & (bit_cnt == `SER_FRAME_BITS)
                      & ~is_read;

  assign link.sdata_d_out = out_sh[7];
  assign link.sdata_d_oe  = out_oe;

  always_comb begin
    rd_value = `RST_BYTE;
    // read data loads after eight bits, address then in the low seven
    case (in_sh[6:0])
      `REG_MODE:     rd_value = {3'h0, mod_method_sel, sync_en,
                                 op_state_sel};
      `REG_A1:       rd_value = {2'h0, set1_swallow_count};
      `REG_N1_HI:    rd_value = {4'h0, set1_main_divider[11:8]};
      `REG_N1_LO:    rd_value = set1_main_divider[7:0];
      `REG_M1_HI:    rd_value = {4'h0, set1_ref_divider[11:8]};
      `REG_M1_LO:    rd_value = set1_ref_divider[7:0];
      `REG_BIAS:     rd_value = bias_config;
      `REG_FEE_CTRL: rd_value = {4'h0, error_est_ctrl};
      `REG_FEE_RES:  rd_value = freq_error_estimate;
      default:       rd_value = `RST_BYTE;
    endcase
  end

  always_comb begin
    next_bit_cnt = bit_cnt;
    next_in_sh   = in_sh;
    next_out_sh  = out_sh;
    next_out_oe  = out_oe;
    if (!link.sen) begin
      next_bit_cnt = 5'h00;
      next_out_oe  = 1'b0;
    end else if (sclk_rise && bit_cnt != `SER_FRAME_BITS) begin
      next_in_sh   = {in_sh[14:0], link.sdata_line};
      next_bit_cnt = bit_cnt + 5'h01;
    end else if (sclk_fall) begin
      // bit 15 sits at in_sh[7] after eight bits
      if (bit_cnt == `SER_DATA_START && in_sh[7]) begin
        next_out_sh = rd_value;
        next_out_oe = 1'b1;
      end else if (out_oe && bit_cnt != `SER_FRAME_BITS) begin
        next_out_sh = {out_sh[6:0], 1'b0};
      end
    end
  end

  always_comb begin
    next_op_state_sel   = op_state_sel;
    next_sync_en        = sync_en;
    next_mod_method_sel = mod_method_sel;
    next_swallow        = set1_swallow_count;
    next_main_div       = set1_main_divider;
    next_ref_div        = set1_ref_divider;
    next_bias           = bias_config;
    next_fee_ctrl       = error_est_ctrl;
    if (do_write) begin
      case (frame_addr)
        `REG_MODE: begin
          next_op_state_sel = frame_data[`MODE_OP_HI:`MODE_OP_LO];
          next_sync_en      = frame_data[`MODE_SYNC_BIT];
          // reserved code keeps the previous method
          if (frame_data[`MODE_MOD_HI:`MODE_MOD_LO] != MOD_RESERVED) begin
            next_mod_method_sel = frame_data[`MODE_MOD_HI:`MODE_MOD_LO];
          end
        end
        `REG_A1:       next_swallow = frame_data[5:0];
        `REG_N1_HI:    next_main_div[11:8] = frame_data[3:0];
        `REG_N1_LO:    next_main_div[7:0] = frame_data;
        `REG_M1_HI:    next_ref_div[11:8] = frame_data[3:0];
        `REG_M1_LO:    next_ref_div[7:0] = frame_data;
        `REG_BIAS:     next_bias = frame_data;
        `REG_FEE_CTRL: next_fee_ctrl = frame_data[3:0];
        `REG_FEE_RES:  next_fee_ctrl = error_est_ctrl;
        default:       next_fee_ctrl = error_est_ctrl;
      endcase
    end
  end

  fee_counter u_fee (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .mode     (error_est_ctrl[1:0]),
    .up_pulse (fee_up_pulse),
    .dn_pulse (fee_dn_pulse),
    .value    (freq_error_estimate)
  );

  assign op_state    = op_state_e'(op_state_sel);
  assign mod_method  = mod_method_sel;
  assign xco_en      = (op_state != OP_POWER_DOWN);
  assign rx_chain_en = (op_state == OP_RECEIVE);
  assign tx_chain_en = (op_state == OP_TRANSMIT);
  // the amplifier stage stays off in every documented mode
  assign pa_stage_en = 1'b0;

  always_comb begin
    next_phase = (phase == `BIT_PERIOD - 8'h01) ? 8'h00 : phase + 8'h01;
    next_rx_q  = rx_q;
    next_tx_q  = tx_q;
    // edges in the received data re-centre the sampling phase
    if (sync_en && rx_chain_en && demod_data != demod_q) begin
      next_phase = 8'h00;
    end
    if (!sync_en) begin
      next_rx_q = demod_data;
      next_tx_q = tx_data_in;
    end else begin
      if (phase == `BIT_HALF) begin
        next_rx_q = demod_data;
      end
      if (phase == 8'h00) begin
        next_tx_q = tx_data_in;
      end
    end
  end

  assign rx_data_out = rx_q;
  assign tx_mod_data = tx_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_q             <= 1'b0;
      sen_q              <= 1'b0;
      bit_cnt            <= 5'h00;
      in_sh              <= 16'h0000;
      out_sh             <= `RST_BYTE;
      out_oe             <= 1'b0;
      op_state_sel       <= 2'h0;
      sync_en            <= 1'b0;
      mod_method_sel     <= 2'h0;
      set1_swallow_count <= `RST_A1;
      set1_main_divider  <= `RST_DIV;
      set1_ref_divider   <= `RST_DIV;
      bias_config        <= `RST_BYTE;
      error_est_ctrl     <= 4'h0;
      phase              <= 8'h00;
      demod_q            <= 1'b0;
      rx_q               <= 1'b0;
      tx_q               <= 1'b0;
      bit_clock_out_pin  <= 1'b0;
    end else begin
      sclk_q             <= link.sclk;
      sen_q              <= link.sen;
      bit_cnt            <= next_bit_cnt;
      in_sh              <= next_in_sh;
      out_sh             <= next_out_sh;
      out_oe             <= next_out_oe;
      op_state_sel       <= next_op_state_sel;
      sync_en            <= next_sync_en;
      mod_method_sel     <= next_mod_method_sel;
      set1_swallow_count <= next_swallow;
      set1_main_divider  <= next_main_div;
      set1_ref_divider   <= next_ref_div;
      bias_config        <= next_bias;
      error_est_ctrl     <= next_fee_ctrl;
      phase              <= next_phase;
      demod_q            <= demod_data;
      rx_q               <= next_rx_q;
      tx_q               <= next_tx_q;
      // pin only toggles in transmit with the synchroniser on
      bit_clock_out_pin  <= sync_en & tx_chain_en
                            & (next_phase < `BIT_HALF);
    end
  end
endmodule : xcvr_device

// ==== xcvr_host.sv ====
`timescale 1ns/1ps
`include "xcvr_consts.svh"
module xcvr_host import xcvr_pkg::*; (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  cfg_link_if.host         link
);
  host_state_e state;
  host_state_e next_state;
  logic [3:0]  half_cnt;
  logic [4:0]  bit_cnt;
  logic [15:0] tx_sh;
  logic [7:0]  rx_sh;
  logic        rd_frame;
  logic        refused;
  logic        sclk_r;
  logic        sen_r;
  logic        oe_r;
  logic [3:0]  next_half_cnt;
  logic [4:0]  next_bit_cnt;
  logic [15:0] next_tx_sh;
  logic [7:0]  next_rx_sh;
  logic        next_rd_frame;
  logic        next_refused;
  logic        next_sclk;
  logic        next_sen;
  logic        next_oe;
  logic [31:0] next_prdata;
  logic [15:0] frame;
  logic        cmd_wr;
  logic        busy;
  logic        half_done;

  assign pready    = 1'b1;
  assign pslverr   = 1'b0;
  assign busy      = (state != H_IDLE);
  assign cmd_wr    = psel & penable & pwrite & (paddr == `APB_CMD);
  assign half_done = (half_cnt == `SCLK_HALF - 4'h1);

  assign link.sclk        = sclk_r;
  assign link.sen         = sen_r;
  assign link.sdata_h_out = tx_sh[15];
  assign link.sdata_h_oe  = oe_r;

  // every bias bit is fixed, so the written byte is replaced
  always_comb begin
    frame = pwdata[15:0];
    if (pwdata[`SER_ADDR_HI:`SER_ADDR_LO] == `REG_BIAS) begin
      frame[7:0] = `BIAS_HALVER_VAL
                 | `BIAS_OSC_VAL
                 | `BIAS_AMP_VAL
                 | `BIAS_BUF_VAL;
    end
  end

  always_comb begin
    next_state    = state;
    next_half_cnt = half_done ? 4'h0 : half_cnt + 4'h1;
    next_bit_cnt  = bit_cnt;
    next_tx_sh    = tx_sh;
    next_rx_sh    = rx_sh;
    next_rd_frame = rd_frame;
    next_refused  = refused;
    next_sclk     = sclk_r;
    next_sen      = sen_r;
    next_oe       = oe_r;
    case (state)
      H_IDLE: begin
        next_half_cnt = 4'h0;
        if (cmd_wr) begin
          // reserved modulation code never reaches the link
          if (pwdata[`SER_ADDR_HI:`SER_ADDR_LO] == `REG_MODE
              && !pwdata[`SER_RW_BIT]
              && pwdata[`MODE_MOD_HI:`MODE_MOD_LO] == MOD_RESERVED) begin
            next_refused = 1'b1;
          end else begin
            next_refused  = 1'b0;
            next_tx_sh    = frame;
            next_rd_frame = pwdata[`SER_RW_BIT];
            next_bit_cnt  = 5'h00;
            next_sen      = 1'b1;
            next_oe       = 1'b1;
            next_state    = H_LOW;
          end
        end
      end
      H_LOW: begin
        if (half_done) begin
          next_sclk    = 1'b1;
          next_bit_cnt = bit_cnt + 5'h01;
          if (rd_frame && bit_cnt >= `SER_DATA_START) begin
            next_rx_sh = {rx_sh[6:0], link.sdata_line};
          end
          next_state = H_HIGH;
        end
      end
      H_HIGH: begin
        if (half_done) begin
          next_sclk  = 1'b0;
          next_tx_sh = {tx_sh[14:0], 1'b0};
          if (rd_frame && bit_cnt == `SER_DATA_START) begin
            next_oe = 1'b0;
          end
          next_state = (bit_cnt == `SER_FRAME_BITS) ? H_END : H_LOW;
        end
      end
      H_END: begin
        if (half_done) begin
          next_sen   = 1'b0;
          next_oe    = 1'b0;
          next_state = H_IDLE;
        end
      end
      default: next_state = H_IDLE;
    endcase
  end

  always_comb begin
    next_prdata = prdata;
    if (psel && !penable) begin
      next_prdata = 32'h0000_0000;
      if (paddr == `APB_STATUS) begin
        next_prdata[`ST_BUSY_BIT]         = busy;
        next_prdata[`ST_REFUSED_BIT]      = refused;
        next_prdata[`ST_RD_HI:`ST_RD_LO]  = rx_sh;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state    <= H_IDLE;
      half_cnt <= 4'h0;
      bit_cnt  <= 5'h00;
      tx_sh    <= 16'h0000;
      rx_sh    <= `RST_BYTE;
      rd_frame <= 1'b0;
      refused  <= 1'b0;
      sclk_r   <= 1'b0;
      sen_r    <= 1'b0;
      oe_r     <= 1'b0;
      prdata   <= 32'h0000_0000;
    end else begin
      state    <= next_state;
      half_cnt <= next_half_cnt;
      bit_cnt  <= next_bit_cnt;
      tx_sh    <= next_tx_sh;
      rx_sh    <= next_rx_sh;
      rd_frame <= next_rd_frame;
      refused  <= next_refused;
      sclk_r   <= next_sclk;
      sen_r    <= next_sen;
      oe_r     <= next_oe;
      prdata   <= next_prdata;
    end
  end
endmodule : xcvr_host

// ==== xcvr_checker.sv ====
`timescale 1ns/1ps
module xcvr_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic sen,
  input wire logic sdata_h_out,
  input wire logic sdata_h_oe,
  input wire logic sdata_d_out,
  input wire logic sdata_d_oe,
  input wire logic sdata_line
);
  logic [4:0] rises;
  logic [4:0] next_rises;
  logic       sclk_q;
  logic       next_sclk_q;

  // counts clock rises per frame; cleared only while the frame is closed
  always_comb begin
    next_sclk_q = sclk;
    next_rises  = rises;
    if (!sen) next_rises = 5'h00;
    else if (sclk && !sclk_q) next_rises = rises + 5'h01;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rises  <= 5'h00;
      sclk_q <= 1'b0;
    end else begin
      rises  <= next_rises;
      sclk_q <= next_sclk_q;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_sclk_idle: assert property (!sen |-> !sclk)
    else $error("serial clock moved outside a frame");
  chk_one_driver: assert property (!(sdata_h_oe && sdata_d_oe))
    else $error("both ends drive the data line");
  chk_sclk_high: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("serial clock high phase not four cycles");
  chk_sclk_low: assert property ($fell(sclk) |-> !sclk[*4])
    else $error("serial clock low phase shorter than four cycles");
  chk_frame_len: assert property ($fell(sen) |-> rises == 5'h10)
    else $error("frame closed without sixteen clock rises");
  chk_frame_start: assert property (
    $rose(sen) |-> sdata_h_oe && !sclk && rises == 5'h00)
    else $error("frame opened badly");
  chk_host_hold: assert property (
    sclk && sdata_h_oe |-> $stable(sdata_h_out))
    else $error("host data changed while clock high");
  chk_turnaround: assert property (
    $rose(sdata_d_oe) |-> !$past(sdata_h_oe) && sen)
    else $error("device drove before host released");
  chk_dev_release: assert property ($fell(sen) |-> ##[1:2] !sdata_d_oe)
    else $error("device kept driving after frame");
  chk_end_release: assert property ($fell(sen) |-> !sdata_h_oe)
    else $error("host kept driving after frame");

  cov_read: cover property ($rose(sdata_d_oe));
  cov_frame: cover property ($fell(sen) && rises == 5'h10);
  cov_line_hi: cover property (sen && !sdata_h_oe && sdata_line);
endmodule : xcvr_checker

// ==== testbench.sv ====
`timescale 1ns/1ps
`include "xcvr_consts.svh"
module testbench import xcvr_pkg::*;;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, st;
  logic        demod_data, tx_data_in, fee_up_pulse, fee_dn_pulse;
  logic        xco_en, rx_chain_en, tx_chain_en, pa_stage_en;
  logic        rx_data_out, tx_mod_data, bit_clock_out_pin;
  logic [1:0]  mod_method;
  logic [5:0]  set1_swallow_count;
  logic [11:0] set1_main_divider, set1_ref_divider;
  logic [7:0]  bias_config;
  logic [3:0]  error_est_ctrl;
  int          errors, tests_run;
  // addr, write value, expected read-back (reserved bits dropped)
  logic [23:0] tbl [6] = '{24'h0fff3f, 24'h10fa0a, 24'h115c5c,
                           24'h12f303, 24'h132121, 24'h15f101};

  cfg_link_if link ();
  xcvr_device i_xcvr_device (.clk, .sys_rst, .link(link), .demod_data,
    .tx_data_in, .fee_up_pulse, .fee_dn_pulse, .xco_en, .rx_chain_en,
    .tx_chain_en, .pa_stage_en, .mod_method, .rx_data_out, .tx_mod_data,
    .bit_clock_out_pin, .set1_swallow_count, .set1_main_divider,
    .set1_ref_divider, .bias_config, .error_est_ctrl);
  xcvr_host i_xcvr_host (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .link(link));
  xcvr_checker i_xcvr_checker (.clk, .sys_rst, .sclk(link.sclk),
    .sen(link.sen), .sdata_h_out(link.sdata_h_out),
    .sdata_h_oe(link.sdata_h_oe), .sdata_d_out(link.sdata_d_out),
    .sdata_d_oe(link.sdata_d_oe), .sdata_line(link.sdata_line));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic results();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      results();
    end
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one serial command, then poll until the host is idle again
  task automatic ser(input logic rd, input logic [6:0] a,
                     input logic [7:0] d);
    logic [31:0] q;
    int          n;
    n = 0;
    apb(1'b1, `APB_CMD, {16'h0000, rd, a, d}, q);
    do begin
      apb(1'b0, `APB_STATUS, 32'h0, st);
      n++;
    end while (st[`ST_BUSY_BIT] !== 1'b0 && n < 100);
    if (st[`ST_BUSY_BIT] !== 1'b0) begin
      errors++;
      results();
    end
  endtask : ser

  task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
    ser(1'b1, a, 8'h00);
    check(32'(st[`ST_RD_HI:`ST_RD_LO]), 32'(exp));
  endtask : rdchk

  task automatic pulse(input logic u, input logic dn, input int n);
    repeat (n) begin
      @(posedge clk);
      fee_up_pulse <= u;
      fee_dn_pulse <= dn;
      @(posedge clk);
      fee_up_pulse <= 1'b0;
      fee_dn_pulse <= 1'b0;
    end
  endtask : pulse

  task automatic t_reset();
    logic [31:0] q;
    check(32'({xco_en, rx_chain_en, tx_chain_en, pa_stage_en}), 0);
    apb(1'b0, 12'h008, 32'h0, q);
    check(q, 32'h0);
    check(32'({pready, pslverr}), 32'h2);
    rdchk(`REG_N1_LO, 8'h00);
  endtask : t_reset

  task automatic t_regs();
    for (int i = 0; i < 6; i++) ser(1'b0, tbl[i][22:16], tbl[i][15:8]);
    for (int i = 0; i < 6; i++) rdchk(tbl[i][22:16], tbl[i][7:0]);
    check(32'({set1_swallow_count, error_est_ctrl}), 32'h3f1);
    check(32'({set1_main_divider, set1_ref_divider}), 32'ha5c321);
  endtask : t_regs

  task automatic t_mode();
    for (int i = 0; i < 4; i++) begin
      ser(1'b0, `REG_MODE, 8'(i));
      check(32'({xco_en, rx_chain_en, tx_chain_en, pa_stage_en}),
            32'({i != 0, i == 2, i == 3, 1'b0}));
      rdchk(`REG_MODE, 8'(i));
    end
    rdchk(`REG_A1, 8'h3f);
  endtask : t_mode

  task automatic t_mod();
    for (int i = 0; i < 3; i++) begin
      ser(1'b0, `REG_MODE, 8'({i[1:0], 3'b001}));
      check(32'(mod_method), 32'(i));
    end
    ser(1'b0, `REG_MODE, 8'h1a);
    check(32'({st[`ST_REFUSED_BIT], mod_method, rx_chain_en}), 32'hc);
    ser(1'b0, `REG_MODE, 8'h01);
    check(32'(st[`ST_REFUSED_BIT]), 32'h0);
  endtask : t_mod

  task automatic t_sync();
    int   n;
    logic last;
    ser(1'b0, `REG_MODE, 8'h02);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) demod_data <= i[0];
      @(posedge clk);
      @(negedge clk) check(32'(rx_data_out), 32'(i[0]));
    end
    ser(1'b0, `REG_MODE, 8'h03);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) tx_data_in <= i[0];
      @(posedge clk);
      @(negedge clk);
      check(32'({tx_mod_data, bit_clock_out_pin}), 32'({i[0], 1'b0}));
    end
    ser(1'b0, `REG_MODE, 8'h07);
    n = 0;
    repeat (32) @(negedge clk) if (bit_clock_out_pin === 1'b1) n++;
    check(32'(n), 32'h10);
    // new data waits for the next bit clock rise
    n = 0;
    last = 1'b1;
    while (n < 40 && !(last === 1'b0 && bit_clock_out_pin === 1'b1)) begin
      last = bit_clock_out_pin;
      @(negedge clk);
      n++;
    end
    if (n == 40) begin
      errors++;
      results();
    end
    @(posedge clk) tx_data_in <= !tx_data_in;
    repeat (7) @(posedge clk);
    @(negedge clk) check(32'(tx_mod_data), 32'(!tx_data_in));
    repeat (9) @(posedge clk);
    @(negedge clk) check(32'(tx_mod_data), 32'(tx_data_in));
    // constant toggling keeps re-centring the phase, so the sampler stops sampling and the output changes at most twice
    ser(1'b0, `REG_MODE, 8'h06);
    n = 0;
    last = rx_data_out;
    repeat (32) begin
      @(posedge clk) demod_data <= ~demod_data;
      @(negedge clk) if (rx_data_out !== last) n++;
      last = rx_data_out;
    end
    check(32'(n <= 2), 32'h1);
    // a held level is sampled mid-bit, ten clocks after its edge
    repeat (20) @(posedge clk);
    last = demod_data;
    @(posedge clk) demod_data <= !last;
    repeat (5) @(posedge clk);
    @(negedge clk) check(32'(rx_data_out), 32'(last));
    repeat (6) @(posedge clk);
    @(negedge clk) check(32'(rx_data_out), 32'(!last));
  endtask : t_sync

  task automatic t_bias();
    ser(1'b0, `REG_BIAS, 8'h00);
    check(32'(bias_config), 32'hb5);
    rdchk(`REG_BIAS, 8'hb5);
  endtask : t_bias

  task automatic t_fee();
    pulse(1'b1, 1'b0, 3);
    rdchk(`REG_FEE_RES, 8'h03);
    pulse(1'b0, 1'b1, 2);
    rdchk(`REG_FEE_RES, 8'h03);
    ser(1'b0, `REG_FEE_RES, 8'h55);
    rdchk(`REG_FEE_RES, 8'h03);
    ser(1'b0, `REG_FEE_CTRL, 8'h00);
    pulse(1'b1, 1'b1, 2);
    pulse(1'b1, 1'b0, 1);
    rdchk(`REG_FEE_RES, 8'h03);
    ser(1'b0, `REG_FEE_CTRL, 8'h03);
    pulse(1'b1, 1'b0, 2);
    pulse(1'b0, 1'b1, 1);
    pulse(1'b1, 1'b1, 1);
    rdchk(`REG_FEE_RES, 8'h04);
    ser(1'b0, `REG_FEE_CTRL, 8'h02);
    pulse(1'b1, 1'b0, 2);
    rdchk(`REG_FEE_RES, 8'h04);
    pulse(1'b0, 1'b1, 1);
    rdchk(`REG_FEE_RES, 8'h03);
  endtask : t_fee

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    {demod_data, tx_data_in, fee_up_pulse, fee_dn_pulse} = 4'h0;
    errors = 0;
    tests_run = 0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_regs();
    t_mode();
    t_mod();
    t_sync();
    t_bias();
    t_fee();
    results();
  end
endmodule : testbench
